//--- rf_tag_command_handler.sv
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps

module rf_tag_command_handler
    import rf_tag_pkg::*;
#(
    parameter int NOMINAL_REPLY_CYC_P = NOMINAL_REPLY_CYC,      // Reply delay in cycles.
    parameter int WRITE_CYCLE_CYC_P   = RF_WRITE_CYCLE_TIME_CYC // Programming time in cycles.
)(
    input  wire logic        CLK,          // 40 MHz clock.
    input  wire logic        RST_B,        // Power-off reset, async, low.
    input  wire logic        PSEL,         // APB select.
    input  wire logic        PENABLE,      // APB enable.
    input  wire logic        PWRITE,       // APB direction.
    input  wire logic [11:0] PADDR,        // APB byte address.
    input  wire logic [31:0] PWDATA,       // APB write data.
    output logic      [31:0] PRDATA,       // APB read data.
    output logic             PREADY,       // APB ready.
    output logic             PSLVERR,      // APB error.
    input  wire logic        RX_SOF,       // Request SOF pulse.
    input  wire logic        RX_BYTE_VALID,// Request byte strobe.
    input  wire logic [7:0]  RX_BYTE,      // Request byte, CRC removed.
    input  wire logic        RX_EOF,       // Request EOF rising edge pulse.
    input  wire logic        RX_CRC_OK,    // CRC result, valid with RX_EOF.
    output logic             TX_VALID,     // Reply byte valid.
    output logic      [7:0]  TX_BYTE,      // Reply byte.
    output logic             TX_LAST,      // Last reply byte.
    input  wire logic        TX_READY,     // Modulator takes byte.
    output logic             MEM_REQ,      // Memory request.
    output logic             MEM_WE,       // Memory write.
    output logic      [15:0] MEM_ADDR,     // Block number.
    output logic      [31:0] MEM_WDATA,    // Block write data.
    input  wire logic        MEM_ACK,      // Memory done pulse.
    input  wire logic [31:0] MEM_RDATA,    // Block read data.
    input  wire logic [7:0]  MEM_SEC,      // Sector security status.
    input  wire logic        MEM_FAIL,     // Memory refused or failed.
    input  wire logic [7:0]  MEM_ERR_CODE, // Error code on failure.
    output logic             ACT_PIN_O,    // Activity pin level.
    output logic             ACT_PIN_OE    // Activity pin drive enable.
);

    typedef struct packed {
        state_e          st;
        logic [15:0][7:0] rx;
        logic [4:0]      rx_cnt;
        logic            rx_ovf;
        logic            crc_ok;
        logic [9:0][7:0] tx;
        logic [3:0]      tx_cnt;
        logic [17:0]     tmr;
        logic            wr_long;
        logic            quiet;
        logic            wip_mode;
        logic [63:0]     uid;
        logic [7:0]      dsfid;
        logic [7:0]      afi;
        logic [63:0]     mask;
        logic [6:0]      mlen;
        logic            slots16;
        logic [3:0]      sn;
        logic            option;
        logic            mem_req;
        logic            mem_we;
        logic [15:0]     blk;
        logic [31:0]     wdata;
        logic [7:0]      last_err;
        logic [31:0]     prdata;
        logic            act_oe;
    } state_s;

    localparam logic [17:0] T1_CYC  = 18'(NOMINAL_REPLY_CYC_P);
    localparam logic [17:0] TWR_CYC = 18'(NOMINAL_REPLY_CYC_P + WRITE_CYCLE_CYC_P);

    state_s st_r;
    state_s st_nxt;

    logic [7:0]  flags;
    logic [7:0]  cmd;
    logic        addressed;
    logic [4:0]  bpos;
    logic [4:0]  ipos;
    logic [7:0]  imlen;
    logic [63:0] imask;
    logic [63:0] req_uid;
    logic [15:0] req_blk;
    logic [31:0] req_data;
    logic [8:0]  inv_need;
    logic        afi_ok;
    logic        addr_ok;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic slot_match(logic [63:0] uid, logic [63:0] m, logic [6:0] ml,
                                        logic s16, logic [3:0] sn);
        logic [63:0] lm;
        lm = (ml[6]) ? '1 : ((64'h1 << ml) - 64'h1);
        return (((uid ^ m) & lm) == '0) && (!s16 || (4'(uid >> ml) == sn));
    endfunction : slot_match

    function automatic logic [9:0][7:0] inv_reply(logic [7:0] dsfid, logic [63:0] uid);
        logic [9:0][7:0] t;
        t[0] = RSP_OK;
        t[1] = dsfid;
        for (int i = 0; i < 8; i++)
        begin
            t[i + 2] = uid[8 * i +: 8];
        end
        return t;
    endfunction : inv_reply

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        flags     = st_r.rx[OFS_FLAGS[3:0]];
        cmd       = st_r.rx[OFS_CMD[3:0]];
        addressed = flags[FLG_ADDRESS];
        bpos      = addressed ? OFS_BODY_ADDR : OFS_BODY;
        ipos      = flags[FLG_AFI] ? OFS_BODY + 5'h01 : OFS_BODY;
        imlen     = st_r.rx[ipos[3:0]];
        for (int i = 0; i < 8; i++)
        begin
            imask[8 * i +: 8]   = st_r.rx[4'(ipos + 5'(i) + 5'h01)];
            req_uid[8 * i +: 8] = st_r.rx[4'(OFS_BODY + 5'(i))];
        end
        req_blk  = {st_r.rx[4'(bpos + 5'h01)], st_r.rx[bpos[3:0]]};
        req_data = {st_r.rx[4'(bpos + 5'h05)], st_r.rx[4'(bpos + 5'h04)],
                    st_r.rx[4'(bpos + 5'h03)], st_r.rx[4'(bpos + 5'h02)]};
        inv_need = 9'(ipos) + 9'h001 + ((9'(imlen) + 9'h007) >> 3);
        afi_ok   = !flags[FLG_AFI] || (st_r.rx[OFS_BODY[3:0]] == AFI_ANY)
                   || (st_r.rx[OFS_BODY[3:0]] == st_r.afi);
        // Select state is not kept here, so a select-only request is never ours.
        addr_ok  = !flags[FLG_SELECT] && (addressed ? (req_uid == st_r.uid) : !st_r.quiet);
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        st_nxt = st_r;
        if (st_r.tmr != '1)
        begin
            st_nxt.tmr = st_r.tmr + 18'h00001;
        end
        if (PSEL && !PENABLE)
        begin
            unique case (PADDR)
                ADDR_CTRL:   st_nxt.prdata = {31'h0, st_r.wip_mode};
                ADDR_UID_LO: st_nxt.prdata = st_r.uid[31:0];
                ADDR_UID_HI: st_nxt.prdata = st_r.uid[63:32];
                ADDR_INFO:   st_nxt.prdata = {16'h0, st_r.afi, st_r.dsfid};
                ADDR_STATUS: st_nxt.prdata = {16'h0, st_r.last_err, 4'h0, st_r.st, st_r.quiet};
                default:     st_nxt.prdata = '0;
            endcase
        end
        if (PSEL && PENABLE && PWRITE)
        begin
            unique case (PADDR)
                ADDR_CTRL:   st_nxt.wip_mode = PWDATA[0];
                ADDR_UID_LO: st_nxt.uid[31:0] = PWDATA;
                ADDR_UID_HI: st_nxt.uid[63:32] = PWDATA;
                ADDR_INFO:   {st_nxt.afi, st_nxt.dsfid} = PWDATA[15:0];
                default:     st_nxt.last_err = st_r.last_err;
            endcase
        end

        unique case (st_r.st)
            S_IDLE, S_SLOT:
            begin
                if (RX_SOF)
                begin
                    st_nxt.st     = S_RECV;
                    st_nxt.rx_cnt = '0;
                    st_nxt.rx_ovf = 1'b0;
                end
                else if (RX_EOF && st_r.st == S_SLOT && st_r.sn != 4'hF)
                begin
                    st_nxt.sn  = st_r.sn + 4'h1;
                    st_nxt.tmr = '0;
                    if (slot_match(st_r.uid, st_r.mask, st_r.mlen, 1'b1, st_r.sn + 4'h1))
                    begin
                        st_nxt.tx      = inv_reply(st_r.dsfid, st_r.uid);
                        st_nxt.tx_cnt  = TX_INV_LEN;
                        st_nxt.wr_long = 1'b0;
                        st_nxt.st      = S_WAIT;
                    end
                end
            end
            S_RECV:
            begin
                if (RX_BYTE_VALID)
                begin
                    if (st_r.rx_cnt == RX_DEPTH)
                    begin
                        st_nxt.rx_ovf = 1'b1;
                    end
                    else
                    begin
                        st_nxt.rx[st_r.rx_cnt[3:0]] = RX_BYTE;
                        st_nxt.rx_cnt = st_r.rx_cnt + 5'h01;
                    end
                end
                if (RX_EOF)
                begin
                    st_nxt.st     = S_DECODE;
                    st_nxt.tmr    = '0;
                    st_nxt.crc_ok = RX_CRC_OK;
                end
            end
            S_DECODE:
            begin
                st_nxt.st      = S_IDLE;
                st_nxt.wr_long = 1'b0;
                st_nxt.option  = flags[FLG_OPTION];
                st_nxt.tx[0]   = RSP_ERROR;
                st_nxt.tx_cnt  = 4'h2;
                if (!st_r.crc_ok || st_r.rx_ovf || st_r.rx_cnt < OFS_BODY)
                begin
                    st_nxt.st = S_IDLE;
                end
                else if (flags[FLG_INVENTORY])
                begin
                    // A quiet tag drops every inventory request.
                    if (!st_r.quiet && cmd == CMD_INVENTORY && afi_ok
                        && 9'(imlen) <= MASK_MAX_BITS && 9'(st_r.rx_cnt) == inv_need)
                    begin
                        st_nxt.mask    = imask;
                        st_nxt.mlen    = imlen[6:0];
                        st_nxt.slots16 = !flags[FLG_ONE_SLOT];
                        st_nxt.sn      = 4'h0;
                        if (slot_match(st_r.uid, imask, imlen[6:0], !flags[FLG_ONE_SLOT], 4'h0))
                        begin
                            st_nxt.tx     = inv_reply(st_r.dsfid, st_r.uid);
                            st_nxt.tx_cnt = TX_INV_LEN;
                            st_nxt.st     = S_WAIT;
                        end
                        else if (!flags[FLG_ONE_SLOT])
                        begin
                            st_nxt.st = S_SLOT;
                        end
                    end
                end
                else if (addr_ok)
                begin
                    if (cmd == CMD_STAY_QUIET)
                    begin
                        if (addressed && st_r.rx_cnt == OFS_BODY_ADDR)
                        begin
                            st_nxt.quiet = 1'b1;
                        end
                    end
                    else if (cmd == CMD_READ_SINGLE || cmd == CMD_WRITE_SINGLE)
                    begin
                        st_nxt.st = S_WAIT;
                        if (!flags[FLG_PROT_EXT] || st_r.rx_cnt != bpos +
                            ((cmd == CMD_WRITE_SINGLE) ? 5'h06 : 5'h02))
                        begin
                            st_nxt.tx[1]    = ERR_UNSPECIFIED;
                            st_nxt.last_err = ERR_UNSPECIFIED;
                        end
                        else if (req_blk >= NUM_BLOCKS)
                        begin
                            st_nxt.tx[1]    = ERR_NO_BLOCK;
                            st_nxt.last_err = ERR_NO_BLOCK;
                        end
                        else
                        begin
                            st_nxt.st      = S_MEM;
                            st_nxt.mem_req = 1'b1;
                            st_nxt.mem_we  = (cmd == CMD_WRITE_SINGLE);
                            st_nxt.wr_long = (cmd == CMD_WRITE_SINGLE);
                            st_nxt.blk     = req_blk;
                            st_nxt.wdata   = req_data;
                        end
                    end
                end
            end
            S_MEM:
            begin
                if (MEM_ACK)
                begin
                    st_nxt.mem_req = 1'b0;
                    st_nxt.st      = S_WAIT;
                    if (MEM_FAIL)
                    begin
                        st_nxt.tx[0]    = RSP_ERROR;
                        st_nxt.tx[1]    = MEM_ERR_CODE;
                        st_nxt.tx_cnt   = 4'h2;
                        st_nxt.last_err = MEM_ERR_CODE;
                    end
                    else if (st_r.mem_we)
                    begin
                        st_nxt.tx[0]  = RSP_OK;
                        st_nxt.tx_cnt = 4'h1;
                    end
                    else
                    begin
                        st_nxt.tx[0] = RSP_OK;
                        st_nxt.tx[1] = {3'h0, MEM_SEC[4:0]};
                        for (int i = 0; i < 4; i++)
                        begin
                            st_nxt.tx[4'(i + 1) + 4'(st_r.option)] = MEM_RDATA[8 * i +: 8];
                        end
                        st_nxt.tx_cnt = st_r.option ? 4'h6 : 4'h5;
                    end
                end
            end
            S_WAIT:
            begin
                // Replies leave only after the nominal delay, writes that reach the memory after programming too.
                if (st_r.tmr >= (st_r.wr_long ? TWR_CYC : T1_CYC))
                begin
                    st_nxt.st = S_SEND;
                end
            end
            S_SEND:
            begin
                if (TX_READY)
                begin
                    st_nxt.tx     = {8'h00, st_r.tx[9:1]};
                    st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
                    if (st_r.tx_cnt == 4'h1)
                    begin
                        st_nxt.st = S_IDLE;
                    end
                end
            end
            default:
            begin
                st_nxt.st = S_IDLE;
            end
        endcase

        // Busy mode holds the pin low for every live command, a pending slot included.
        st_nxt.act_oe = st_nxt.wip_mode
                      ? (st_nxt.wr_long && (st_nxt.st == S_MEM || st_nxt.st == S_WAIT))
                      : (st_nxt.st != S_IDLE);
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_r       <= '0;
            st_r.st    <= S_IDLE;
            st_r.tmr   <= '1;
            st_r.uid   <= UID_RESET;
            st_r.dsfid <= DSFID_RESET;
            st_r.afi   <= AFI_RESET;
            st_r.quiet <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign PRDATA     = st_r.prdata;
    assign PREADY     = 1'b1;
    assign PSLVERR    = PSEL && PENABLE && (PADDR != ADDR_CTRL) && (PADDR != ADDR_UID_LO)
                        && (PADDR != ADDR_UID_HI) && (PADDR != ADDR_INFO)
                        && (PWRITE || PADDR != ADDR_STATUS);
    assign TX_VALID   = (st_r.st == S_SEND);
    assign TX_BYTE    = st_r.tx[0];
    assign TX_LAST    = (st_r.st == S_SEND) && (st_r.tx_cnt == 4'h1);
    assign MEM_REQ    = st_r.mem_req;
    assign MEM_WE     = st_r.mem_we;
    assign MEM_ADDR   = st_r.blk;
    assign MEM_WDATA  = st_r.wdata;
    assign ACT_PIN_O  = 1'b0;
    assign ACT_PIN_OE = st_r.act_oe;

    ////////////////////////////////////////////////////////////////////////////////

    a_reply_delay: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(TX_VALID) |-> st_r.tmr > T1_CYC)
        else $error("Reply started before the nominal delay.");

    a_write_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(TX_VALID) && st_r.wr_long |-> st_r.tmr > TWR_CYC)
        else $error("Write reply before programming time.");

    a_quiet_drop: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r.st == S_DECODE && st_r.quiet && flags[FLG_INVENTORY] |=> st_r.st == S_IDLE)
        else $error("Quiet tag acted on inventory.");

    a_quiet_silent: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r.st == S_DECODE && !flags[FLG_INVENTORY] && cmd == CMD_STAY_QUIET
        |=> st_r.st == S_IDLE ##1 !TX_VALID)
        else $error("Stay quiet produced a reply.");

    a_inv_crc_err: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r.st == S_DECODE && !st_r.crc_ok |=> st_r.st == S_IDLE [*2])
        else $error("Errored request was not dropped.");

    a_inv_len: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(st_r.st == S_WAIT) && $past(flags[FLG_INVENTORY]) |-> st_r.tx_cnt == TX_INV_LEN)
        else $error("Inventory reply has wrong length.");

    a_busy_pin: assert property (@(posedge CLK) disable iff (!RST_B)
        !st_r.wip_mode && !$past(st_r.wip_mode) && TX_VALID |-> ACT_PIN_OE && !ACT_PIN_O)
        else $error("Busy pin released during reply.");

    a_wip_release: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r.wip_mode && $past(st_r.wip_mode) && (st_r.st == S_SLOT || TX_VALID) |-> !ACT_PIN_OE)
        else $error("Write-progress pin driven outside programming.");

    a_wip_low: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r.wip_mode && st_r.st == S_MEM && st_r.mem_we && $stable(st_r.wip_mode)
        |-> ACT_PIN_OE)
        else $error("Write-progress pin idle during programming.");

    a_pe_error: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r.st == S_DECODE && st_r.crc_ok && !st_r.rx_ovf && addr_ok && !flags[FLG_INVENTORY]
        && !flags[FLG_PROT_EXT] && cmd == CMD_READ_SINGLE && st_r.rx_cnt >= OFS_BODY
        |=> st_r.st == S_WAIT && st_r.tx[0] == RSP_ERROR)
        else $error("Missing error reply for clear extension flag.");

endmodule : rf_tag_command_handler

//--- rf_tag_pkg.sv
package rf_tag_pkg;

    // Command codes.
    localparam logic [7:0] CMD_INVENTORY    = 8'h01;
    localparam logic [7:0] CMD_STAY_QUIET   = 8'h02;
    localparam logic [7:0] CMD_READ_SINGLE  = 8'h20;
    localparam logic [7:0] CMD_WRITE_SINGLE = 8'h21;

    // Error codes.
    localparam logic [7:0] ERR_UNSPECIFIED  = 8'h0F;
    localparam logic [7:0] ERR_NO_BLOCK     = 8'h10;
    localparam logic [7:0] ERR_LOCKED       = 8'h12;
    localparam logic [7:0] ERR_PROG_FAIL    = 8'h13;
    localparam logic [7:0] ERR_READ_PROT    = 8'h15;

    // Response flag bytes.
    localparam logic [7:0] RSP_OK           = 8'h00;
    localparam logic [7:0] RSP_ERROR        = 8'h01;

    // Request flag bit positions.
    localparam int FLG_INVENTORY = 2;
    localparam int FLG_PROT_EXT  = 3;
    localparam int FLG_SELECT    = 4;
    localparam int FLG_ADDRESS   = 5;
    localparam int FLG_OPTION    = 6;
    localparam int FLG_AFI       = 4;
    localparam int FLG_ONE_SLOT  = 5;

    // Request byte layout, frame lengths and limits.
    localparam logic [4:0] OFS_FLAGS     = 5'h00;
    localparam logic [4:0] OFS_CMD       = 5'h01;
    localparam logic [4:0] OFS_BODY      = 5'h02;
    localparam logic [4:0] OFS_BODY_ADDR = 5'h0A;
    localparam logic [4:0] RX_DEPTH      = 5'h10;
    localparam logic [3:0] TX_INV_LEN    = 4'hA;
    localparam logic [8:0] MASK_MAX_BITS = 9'h040;
    localparam logic [7:0] AFI_ANY       = 8'h00;
    localparam logic [15:0] NUM_BLOCKS   = 16'h0800;

    // Timing at a 25 ns clock.
    localparam int CLK_PERIOD_NS           = 25;
    localparam int NOMINAL_REPLY_TIME_NS   = 320900;
    localparam int RF_WRITE_PERIOD_NS      = 302000;
    localparam int RF_WRITE_PERIODS        = 18;
    localparam int NOMINAL_REPLY_CYC       = NOMINAL_REPLY_TIME_NS / CLK_PERIOD_NS;
    localparam int RF_WRITE_CYCLE_TIME_CYC =
        RF_WRITE_PERIODS * RF_WRITE_PERIOD_NS / CLK_PERIOD_NS;

    // APB map.
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_UID_LO = 12'h004;
    localparam logic [11:0] ADDR_UID_HI = 12'h008;
    localparam logic [11:0] ADDR_INFO   = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    // Arbitrary identifier value.
    localparam logic [63:0] UID_RESET   = 64'h1122334455667788;
    localparam logic [7:0]  DSFID_RESET = 8'h00;
    localparam logic [7:0]  AFI_RESET   = 8'h00;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_RECV   = 3'b001,
        S_DECODE = 3'b010,
        S_SLOT   = 3'b011,
        S_MEM    = 3'b100,
        S_WAIT   = 3'b101,
        S_SEND   = 3'b110
    } state_e;

endpackage : rf_tag_pkg

//--- vcd_model.sv
`timescale 1ns/1ps
module vcd_model (
    input  wire logic       CLK,           // Tag clock.
    output logic            RX_SOF,        // Frame start.
    output logic            RX_BYTE_VALID, // Byte strobe.
    output logic      [7:0] RX_BYTE,       // Request byte.
    output logic            RX_EOF,        // Frame end.
    output logic            RX_CRC_OK,     // Frame check result.
    output logic            TX_READY       // Reply byte taken.
);
    initial {RX_SOF, RX_BYTE_VALID, RX_BYTE, RX_EOF, RX_CRC_OK, TX_READY} = '0;
    // Taking every other cycle keeps the tag waiting on a slow demodulator.
    always @(posedge CLK) TX_READY <= ~TX_READY;
    // The caller waits for the reply or the slot time before the next frame.
    task automatic send(input logic [7:0] b[12], input int n, input logic ok);
        @(posedge CLK) RX_SOF <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge CLK) {RX_SOF, RX_BYTE_VALID, RX_BYTE} <= {2'b01, b[i]};
        end
        @(posedge CLK) {RX_BYTE_VALID, RX_BYTE, RX_EOF, RX_CRC_OK} <= {1'b0, ~RX_BYTE, 1'b1, ok};
        @(posedge CLK) RX_EOF <= 1'b0;
    endtask : send
    // A slot marker is a bare EOF; the caller keeps the empty-slot wait before it.
    task automatic mark;
        @(posedge CLK) RX_EOF <= 1'b1;
        @(posedge CLK) RX_EOF <= 1'b0;
    endtask : mark
endmodule : vcd_model

//--- tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
    import rf_tag_pkg::*;
    logic        CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, MEM_ACK = 0;
    logic        wip = 0, fin, oe_seen, err;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, prd, MEM_WDATA;
    logic        PREADY, PSLVERR, RX_SOF, RX_BYTE_VALID, RX_EOF, RX_CRC_OK;
    logic        TX_VALID, TX_LAST, TX_READY, MEM_REQ, MEM_WE, ACT_PIN_O, ACT_PIN_OE;
    logic [7:0]  RX_BYTE, TX_BYTE, req[12], got[$];
    logic [15:0] MEM_ADDR;
    int          miscompares = 0, checked = 0, cyc = 0, lat = 0, ticks = 0;
    // Row: crc ok, flags, command, block, reply length, first two reply bytes.
    logic [63:0] rows[9] = '{64'h01_08_20_0005_05_00_D4, 64'h01_48_20_0005_06_00_1F,
        64'h01_00_20_0005_02_01_0F, 64'h01_08_20_0800_02_01_10, 64'h01_08_20_0007_02_01_15,
        64'h01_08_21_0005_01_00_00, 64'h01_08_21_0007_02_01_12, 64'h01_00_21_0005_02_01_0F,
        64'h00_08_20_0005_00_00_00};
    rf_tag_command_handler #(.NOMINAL_REPLY_CYC_P(20), .WRITE_CYCLE_CYC_P(50)) DUT (.CLK, .RST_B,
        .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RX_SOF,
        .RX_BYTE_VALID, .RX_BYTE, .RX_EOF, .RX_CRC_OK, .TX_VALID, .TX_BYTE, .TX_LAST, .TX_READY,
        .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_ACK, .MEM_RDATA(32'hA1B2C3D4),
        .MEM_SEC(8'hFF), .MEM_FAIL(MEM_ADDR == 16'h0007), .MEM_ERR_CODE(MEM_WE ? 8'h12 : 8'h15),
        .ACT_PIN_O, .ACT_PIN_OE);
    vcd_model rdr (.CLK, .RX_SOF, .RX_BYTE_VALID, .RX_BYTE, .RX_EOF, .RX_CRC_OK, .TX_READY);
    ////////////////////////////////////////////////////////////////////////////////////////////
    always #12.5 CLK = ~CLK;
    always @(posedge CLK)
    begin
        MEM_ACK <= MEM_REQ && !MEM_ACK;
        // Set only, so only the clear at the start of a transfer resets it.
        if (ACT_PIN_OE) oe_seen <= 1'b1;
        cyc <= RX_EOF ? 0 : cyc + 1;
        if (MEM_REQ && MEM_WE && !MEM_ACK)
            `CHK({MEM_ADDR, MEM_WDATA}, {req[3], req[2], req[7], req[6], req[5], req[4]})
        if (TX_VALID && TX_READY)
        begin
            if (got.size() == 0) lat = cyc;
            got.push_back(TX_BYTE);
            fin <= TX_LAST;
            `CHK(ACT_PIN_OE, !wip)
            `CHK(ACT_PIN_O, 1'b0)
        end
        ticks++;
        if (ticks == 20000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge CLK) PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1) @(posedge CLK);
        prd = PRDATA;
        err = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
        @(posedge CLK);
    endtask : apb
    task automatic xfer(input int n, input logic ok, input int nexp);
        got = {};
        fin = 0;
        oe_seen = 0;
        rdr.send(req, n, ok);
        for (int i = 0; i < 300 && !fin; i++) @(posedge CLK);
        repeat (3) @(posedge CLK);
        `CHK(got.size(), nexp)
    endtask : xfer
    ////////////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        req = '{4: 8'h11, 5: 8'h22, 6: 8'h33, 7: 8'h44, default: 8'h00};
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        foreach (rows[i])
        begin
            {req[0], req[1], req[3], req[2]} = rows[i][55:24];
            xfer(rows[i][40] ? 8 : 4, rows[i][56], int'(rows[i][23:16]));
            if (got.size() > 0) `CHK(got[0], rows[i][15:8])
            if (got.size() > 1) `CHK(got[1], rows[i][7:0])
            // Only a write that reaches the memory waits for the programming time.
            if (got.size() > 0) `CHK(lat >= (rows[i][40] && rows[i][51] ? 70 : 20), 1'b1)
        end
        req = '{0: 8'h26, 1: 8'h01, default: 8'h00};
        xfer(3, 1'b1, 10);
        `CHK(got[2], UID_RESET[7:0])
        {req[0], req[1]} = {8'h20, 8'h02};
        for (int k = 0; k < 8; k++) req[2 + k] = UID_RESET[8 * k +: 8];
        xfer(10, 1'b1, 0);
        `CHK(oe_seen, 1'b1)
        {req[0], req[1]} = {8'h28, 8'h20};
        req[10] = 8'h05;
        xfer(12, 1'b1, 5);
        {req[0], req[1], req[2]} = {8'h26, 8'h01, 8'h00};
        xfer(3, 1'b1, 0);
        RST_B <= 1'b0;
        @(posedge CLK) RST_B <= 1'b1;
        @(posedge CLK);
        xfer(3, 1'b1, 10);
        // Sixteen slots, empty mask: the identifier's low nibble picks slot 8.
        req[0] = 8'h06;
        xfer(3, 1'b1, 0);
        for (int s = 0; s < 8; s++)
        begin
            `CHK({got.size() == 0, ACT_PIN_OE}, 2'b11)
            repeat (30) @(posedge CLK);
            rdr.mark();
        end
        for (int i = 0; i < 300 && !fin; i++) @(posedge CLK);
        `CHK(got.size(), 10)
        `CHK(lat >= 20, 1'b1)
        apb(1'b0, ADDR_UID_LO, 32'h0);
        `CHK(prd, UID_RESET[31:0])
        apb(1'b1, 12'h020, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, ADDR_CTRL, 32'h1);
        wip = 1'b1;
        {req[0], req[1], req[2], req[3]} = {8'h08, 8'h20, 8'h05, 8'h00};
        xfer(4, 1'b1, 5);
        `CHK(oe_seen, 1'b0)
        req[1] = 8'h21;
        xfer(8, 1'b1, 1);
        `CHK(oe_seen, 1'b1)
        give_verdict();
    end
endmodule : tb_top
